// >>> ffs_pkg.sv
package ffs_pkg;
  localparam int PC_W = 12;
  localparam int INSN_W = 16;
  localparam logic [11:0] RESET_VECTOR = 12'h000;
  localparam int PAGE_BITS = 8;
  // Wake-up start-up waits in system clocks.
  localparam logic [4:0] WAKE_CLKS_HS = 5'h10;
  localparam logic [4:0] WAKE_CLKS_LS = 5'h02;
  localparam logic [1:0] PH_FIRST = 2'h0;
  localparam logic [1:0] PH_LAST = 2'h3;
  typedef enum logic [3:0]
  {
    FFS_HALT = 4'h1,
    FFS_WAKE = 4'h2,
    FFS_RUN = 4'h4,
    FFS_DUMMY = 4'h8
  } ffs_state_t;
endpackage

// >>> ffs_phase_gen.sv
`timescale 1ns/1ps
module ffs_phase_gen (
  clk,
  sys_rst,
  run,
  phase
);
  import ffs_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic run;
  output logic [3:0] phase;
  logic [1:0] cnt;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      cnt <= PH_FIRST;
    else if (!run)
      cnt <= PH_FIRST;
    else
      cnt <= cnt + 2'h1;
  end
  // One-hot phase strobes; exactly one active per clock while running.
  assign phase = run ? (4'h1 << cnt) : 4'h0;
  ph_onehot_a: assert property (@(posedge clk) disable iff (sys_rst)
    run |-> $onehot(phase)) else $error("phase not one-hot");
  ph_rotate_a: assert property (@(posedge clk) disable iff (sys_rst)
    run && phase[3] && $past(run) |=> !run || phase[0])
    else $error("phase rotation broken");
endmodule

// >>> ffs_sequencer.sv
`timescale 1ns/1ps
module ffs_sequencer (
  clk,
  sys_rst,
  halt_req,
  wake_req,
  low_speed_internal_osc,
  prog_addr,
  prog_rd,
  prog_data,
  exec_insn,
  exec_valid,
  exec_phase,
  branch_taken,
  branch_target,
  skip_taken,
  pc_low_byte_wr,
  pc_low_byte,
  pc,
  halted,
  dummy_cycle,
  instruction_phase_clocks
);
  import ffs_pkg::*;
  input wire logic clk;
  input wire logic sys_rst;
  input wire logic halt_req;
  input wire logic wake_req;
  input wire logic low_speed_internal_osc;
  output logic [ffs_pkg::PC_W-1:0] prog_addr;
  output logic prog_rd;
  input wire logic [ffs_pkg::INSN_W-1:0] prog_data;
  output logic [ffs_pkg::INSN_W-1:0] exec_insn;
  output logic exec_valid;
  output logic [2:0] exec_phase;
  input wire logic branch_taken;
  input wire logic [ffs_pkg::PC_W-1:0] branch_target;
  input wire logic skip_taken;
  input wire logic pc_low_byte_wr;
  input wire logic [7:0] pc_low_byte;
  output logic [ffs_pkg::PC_W-1:0] pc;
  output logic halted;
  output logic dummy_cycle;
  output logic [3:0] instruction_phase_clocks;

  ffs_state_t state;
  ffs_state_t next_state;
  logic [4:0] wake_cnt;
  logic [ffs_pkg::INSN_W-1:0] fetch_buf;
  logic fetch_valid;
  logic run;
  wire t1;
  wire t4;
  wire cycle_end;
  wire flush;
  wire [ffs_pkg::PC_W-1:0] page_jump;
  wire [ffs_pkg::PC_W-1:0] redirect_target;

  assign run = (state == FFS_RUN) || (state == FFS_DUMMY);

  ffs_phase_gen u_phase (
    .clk(clk),
    .sys_rst(sys_rst),
    .run(run),
    .phase(instruction_phase_clocks)
  );

  assign t1 = instruction_phase_clocks[0];
  assign t4 = instruction_phase_clocks[3];
  assign cycle_end = t4;
  // Execute strobes for decode and execution during phases two to four.
  assign exec_phase = exec_valid ?
    instruction_phase_clocks[3:1] : 3'h0;
  // A page jump keeps the high bits of the address being executed.
  assign page_jump = {pc[PC_W-1:PAGE_BITS], pc_low_byte};
  assign flush = exec_valid && state == FFS_RUN &&
    (branch_taken || skip_taken || pc_low_byte_wr);
  assign prog_rd = t1 && run;
  assign dummy_cycle = state == FFS_DUMMY;
  assign halted = state == FFS_HALT;

  always_comb
  begin
    next_state = state;
    case (state)
      FFS_HALT:
        if (wake_req)
          next_state = FFS_WAKE;
      FFS_WAKE:
        if (wake_cnt == 5'h01)
          next_state = FFS_RUN;
      FFS_RUN:
        if (cycle_end && halt_req)
          next_state = FFS_HALT;
        else if (cycle_end && flush)
          next_state = FFS_DUMMY;
      FFS_DUMMY:
        if (cycle_end)
          next_state = FFS_RUN;
      default:
        next_state = FFS_HALT;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      state <= FFS_RUN;
    else
      state <= next_state;
  end

  // Start-up timer: loaded on wake, counts system clocks down.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      wake_cnt <= 5'h00;
    else if (state == FFS_HALT && wake_req)
      wake_cnt <= low_speed_internal_osc ? WAKE_CLKS_LS
                                         : WAKE_CLKS_HS;
    else if (state == FFS_WAKE && wake_cnt != 5'h00)
      wake_cnt <= wake_cnt - 5'h01;
  end

  // The target is loaded at the end of the flushed cycle, so the phase one
  // of the dummy cycle already fetches the correct word.
  assign redirect_target = pc_low_byte_wr ? page_jump :
    (branch_taken ? branch_target : prog_addr + 12'h001);

  // Fetch address and pc: pc names the instruction in execution.
  // Halting keeps the prefetched address (the redirect target if a flush ends the same cycle), so that word is fetched on wake.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      prog_addr <= RESET_VECTOR;
    else if (t4 && flush)
      prog_addr <= redirect_target;
    else if (t4 && run && next_state != FFS_HALT)
      prog_addr <= prog_addr + 12'h001;
  end

  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
      fetch_buf <= '0;
    else if (t1 && run)
      fetch_buf <= prog_data;
  end

  // Hand the fetched word to execution at the cycle boundary.
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      exec_insn <= '0;
      exec_valid <= 1'b0;
      pc <= RESET_VECTOR;
      fetch_valid <= 1'b0;
    end
    else if (!run)
    begin
      exec_valid <= 1'b0;
      fetch_valid <= 1'b0;
    end
    else if (t1)
      fetch_valid <= 1'b1;
    else if (t4)
    begin
      exec_insn <= fetch_buf;
      exec_valid <= fetch_valid && next_state == FFS_RUN;
      pc <= prog_addr;
    end
  end

  wake_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == FFS_WAKE |-> !prog_rd && exec_phase == 3'h0)
    else $error("activity during wake delay");
  wake_len_a: assert property (@(posedge clk) disable iff (sys_rst)
    state == FFS_HALT && wake_req && !low_speed_internal_osc
    |=> (state == FFS_WAKE) [*8])
    else $error("wake delay too short");
  fetch_t1_a: assert property (@(posedge clk) disable iff (sys_rst)
    prog_rd |-> instruction_phase_clocks[0])
    else $error("fetch outside phase one");
  pc_inc_a: assert property (@(posedge clk) disable iff (sys_rst)
    t4 && run && !flush && !halt_req
    |=> prog_addr == $past(prog_addr) + 12'h001)
    else $error("fetch address not incremented");
  sequence flush_seen;
    state == FFS_RUN && t4 && flush;
  endsequence
  dummy_ins_a: assert property (@(posedge clk) disable iff (sys_rst)
    flush_seen and (!halt_req) |=> dummy_cycle [*4] ##1 !dummy_cycle)
    else $error("dummy cycle not inserted");
  page_jump_a: assert property (@(posedge clk) disable iff (sys_rst)
    flush_seen and (pc_low_byte_wr)
    |=> prog_addr == $past(page_jump))
    else $error("page jump target wrong");
  target_fetch_a: assert property (@(posedge clk) disable iff (sys_rst)
    flush_seen and (!halt_req)
    |=> prog_rd && prog_addr == $past(redirect_target))
    else $error("redirect target not fetched");
  halt_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    halted |=> $stable(prog_addr))
    else $error("fetch address moved while halted");
  dummy_noexec_a: assert property (@(posedge clk) disable iff (sys_rst)
    dummy_cycle |-> exec_phase == 3'h0)
    else $error("execution in dummy cycle");
  exec_phase_a: assert property (@(posedge clk) disable iff (sys_rst)
    exec_phase != 3'h0 |-> !instruction_phase_clocks[0])
    else $error("execute in phase one");
endmodule

// >>> ffs_prog_mem.sv
`timescale 1ns/1ps
module ffs_prog_mem (
  clk,
  prog_rd,
  prog_addr,
  prog_data
);
  import ffs_pkg::*;
  input wire logic clk;
  input wire logic prog_rd;
  input wire logic [ffs_pkg::PC_W-1:0] prog_addr;
  output logic [ffs_pkg::INSN_W-1:0] prog_data;
  logic [INSN_W-1:0] last = 16'h0000;
  // Each word mirrors its address; off the strobe the bus shows junk.
  assign prog_data = prog_rd ? {4'hA, prog_addr} : ~last;
  always_ff @(posedge clk) last <= prog_data;
endmodule

// >>> four_phase_fetch_execute_sequencer_tb.sv
`timescale 1ns/1ps
module four_phase_fetch_execute_sequencer_tb;
  import ffs_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic halt_req = 1'b0;
  logic wake_req = 1'b0;
  logic lso = 1'b0;
  logic br = 1'b0;
  logic skip = 1'b0;
  logic lwr = 1'b0;
  logic [PC_W-1:0] tgt = 12'h000;
  logic [7:0] low = 8'h00;
  logic [PC_W-1:0] prog_addr, pc;
  logic prog_rd, exec_valid, halted, dummy_cycle;
  logic [INSN_W-1:0] prog_data, exec_insn;
  logic [2:0] exec_phase;
  logic [3:0] ipc;
  int mismatches = 0;
  int cmp_count = 0;
  always #5 clk = ~clk;
  ffs_sequencer u_dut (.clk(clk), .sys_rst(sys_rst), .halt_req(halt_req),
    .wake_req(wake_req), .low_speed_internal_osc(lso),
    .prog_addr(prog_addr), .prog_rd(prog_rd), .prog_data(prog_data),
    .exec_insn(exec_insn), .exec_valid(exec_valid),
    .exec_phase(exec_phase), .branch_taken(br), .branch_target(tgt),
    .skip_taken(skip), .pc_low_byte_wr(lwr), .pc_low_byte(low), .pc(pc),
    .halted(halted), .dummy_cycle(dummy_cycle),
    .instruction_phase_clocks(ipc));
  ffs_prog_mem u_mem (.clk(clk), .prog_rd(prog_rd), .prog_addr(prog_addr),
    .prog_data(prog_data));
  task automatic final_report;
    if (mismatches == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick;
    @(posedge clk);
    #1;
  endtask
  task automatic guard(input int n);
    if (n > 60)
    begin
      mismatches++;
      final_report;
    end
  endtask
  task automatic wait_fetch(output int n);
    n = 0;
    tick;
    while (prog_rd !== 1'b1)
    begin
      n++;
      guard(n);
      tick;
    end
  endtask
  task automatic t_run;
    int n;
    #1;
    check(prog_addr, 16'h0000);
    for (int k = 0; k < 8; k++)
    begin
      check(ipc, 16'h0001 << (k % 4));
      if (k % 4 > 0 && exec_valid === 1'b1)
        check(exec_phase, 16'h0001 << (k % 4 - 1));
      tick;
    end
    check(prog_rd, 16'h0001);
    check(prog_addr, 16'h0002);
    check(exec_insn, 16'hA001);
    check(pc, 16'h0001);
    check(exec_valid, 16'h0001);
  endtask
  task automatic t_reset;
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) tick;
    check({prog_rd, ipc, exec_valid}, 16'h0022);
    check(prog_addr, 16'h0000);
    @(posedge clk);
    sys_rst <= 1'b0;
  endtask
  task automatic t_flush(input int kind);
    int n;
    int d;
    logic [PC_W-1:0] a, e;
    n = 0;
    while (!(ipc[2] === 1'b1 && exec_valid === 1'b1 && dummy_cycle === 1'b0))
    begin
      n++;
      guard(n);
      tick;
    end
    a = pc;
    e = kind == 0 ? 12'h0C5 : kind == 1 ? {a[11:8], 8'h3C} : a + 12'h002;
    @(posedge clk);
    br <= kind == 0;
    tgt <= 12'h0C5;
    lwr <= kind == 1;
    low <= 8'h3C;
    skip <= kind == 2;
    @(posedge clk);
    {br, lwr, skip} <= 3'h0;
    #1;
    check(prog_addr, e);
    check(exec_valid, 16'h0000);
    d = 0;
    for (int k = 0; k < 8; k++)
    begin
      d += dummy_cycle === 1'b1;
      if (dummy_cycle === 1'b1)
        check(exec_phase, 16'h0000);
      tick;
    end
    check(d, 4);
    check(exec_insn, {4'hA, e + 12'h001});
    check(exec_valid, 16'h0001);
  endtask
  task automatic t_wake(input logic ls, input int w);
    int n;
    @(posedge clk);
    halt_req <= 1'b1;
    lso <= ls;
    n = 0;
    while (halted !== 1'b1)
    begin
      n++;
      guard(n);
      tick;
    end
    @(posedge clk);
    halt_req <= 1'b0;
    repeat (3) tick;
    check({prog_rd, ipc}, 16'h0000);
    @(posedge clk);
    wake_req <= 1'b1;
    @(posedge clk);
    wake_req <= 1'b0;
    #1;
    wait_fetch(n);
    check(n >= w - 1 && n <= w + 1, 16'h0001);
    check({halted, exec_valid}, 16'h0000);
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    t_run;
    t_flush(0);
    t_flush(1);
    t_flush(2);
    t_wake(1'b1, WAKE_CLKS_LS);
    t_wake(1'b0, WAKE_CLKS_HS);
    t_reset;
    t_run;
    final_report;
  end
endmodule
